// ==== acc_ctrl.sv ====
// Purpose: digital control around the analog comparator
// Assumes: converter_on and channel_select come from logic on clk
// Notes: comparator and pin levels are asynchronous and synchronised here
// Functional notes
// - comparator output is synchronised, one to two cycles late, then read
// - interrupt flag sets on the event picked by the mode field
// - interrupt flag clears when the cpu enters its vector
// - writing one to the flag clears it, zero leaves it
// - interrupt request needs flag, enable bit and global enable
// - capture route bit feeds comparator into timer capture, else nothing
// - comparator capture interrupts the timer only with its enable set
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - mux enable with converter off picks converter input by channel
// - mux disabled or converter on uses the negative pin
// - input disable bits seven down to two read as zero
// - disable bit turns off pin buffer, pin reads zero
// - power off bit shuts down the comparator at any time
// - bandgap bit replaces the positive pin with a fixed reference
// - mux enable is bit six of converter control b, reset zero
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module acc_ctrl #(
	parameter int SYNC_STAGES = acc_pkg::ACC_SYNC_STAGES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [acc_pkg::ACC_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// block interrupt
	output logic irq,
	// cpu interrupt path
	input wire logic global_irq_enable,
	input wire logic cmp_irq_vector_ack,
	output logic cmp_irq_req,
	// analog comparator core
	input wire logic cmp_raw,
	output logic cmp_power_off,
	output logic cmp_bandgap_select,
	output logic cmp_neg_from_mux,
	output logic [2:0] cmp_neg_channel,
	// converter state
	input wire logic converter_on,
	input wire logic [2:0] channel_select,
	// comparator pins
	input wire logic pos_pin_raw,
	input wire logic neg_pin_raw,
	output logic pos_pin_read,
	output logic neg_pin_read,
	output logic pos_pin_input_disable,
	output logic neg_pin_input_disable,
	// timer input capture
	input wire logic timer_capture_event,
	input wire logic timer_capture_irq_enable,
	output logic cmp_capture_sig,
	output logic cmp_capture_irq
);
	import acc_pkg::*;

	acc_evt_if evt ();

	acc_bus_t bus_state;
	logic req;
	logic commit;
	logic wr_csr;
	logic wr_dis;
	logic wr_convb;
	logic wr_mask;
	logic rd_stat;
	logic [2:0] pin_sync;
	logic cmp_output_sync;
	logic [7:0] csr_rw;
	logic cmp_irq_flag;
	logic [1:0] pin_dis;
	logic cmp_mux_enable;
	logic [ACC_STAT_W-1:0] status;
	logic [ACC_STAT_W-1:0] mask;
	logic [ACC_STAT_W-1:0] stat_clr;
	logic [31:0] rd_value;

	// comparator and both pins cross into clk here
	acc_sync #(
		.WIDTH(3),
		.STAGES(SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.async_in({neg_pin_raw, pos_pin_raw, cmp_raw}),
		.sync_out(pin_sync)
	);

	assign cmp_output_sync = pin_sync[0];
	assign evt.cmp_level = cmp_output_sync;
	assign evt.mode = csr_rw[ACC_CSR_MODE_HI:ACC_CSR_MODE_LO];

	acc_edge u_edge (
		.clk(clk),
		.rstn(rstn),
		.evt(evt.det)
	);

	// bus handshake: one wait cycle, then the access commits
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & (bus_state == ACC_BUS_IDLE);
	assign commit = req & (bus_state == ACC_BUS_DONE);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_state <= ACC_BUS_IDLE;
		end else begin
			unique case (bus_state)
				ACC_BUS_IDLE: begin
					if (req) begin
						bus_state <= ACC_BUS_DONE;
					end
				end
				ACC_BUS_DONE: begin
					bus_state <= ACC_BUS_IDLE;
				end
				default: begin
					bus_state <= ACC_BUS_IDLE;
				end
			endcase
		end
	end

	// write strobes only on the committing edge with lane zero enabled
	assign wr_csr = commit & avs_write & avs_byteenable[0]
		& acc_hit(avs_address, ACC_OFS_CSR);
	assign wr_dis = commit & avs_write & avs_byteenable[0]
		& acc_hit(avs_address, ACC_OFS_PIN_DIS);
	assign wr_convb = commit & avs_write & avs_byteenable[0]
		& acc_hit(avs_address, ACC_OFS_CONV_B);
	assign wr_mask = commit & avs_write & avs_byteenable[0]
		& acc_hit(avs_address, ACC_OFS_MASK);
	assign rd_stat = commit & avs_read & acc_hit(avs_address, ACC_OFS_STATUS);

	// read value; unmapped words and unused bits read zero
	always_comb begin
		rd_value = 32'h00000000;
		if (acc_hit(avs_address, ACC_OFS_CSR)) begin
			rd_value[7:0] = csr_rw & ACC_CSR_RW_MASK;
			rd_value[ACC_CSR_OUTPUT] = cmp_output_sync;
			rd_value[ACC_CSR_FLAG] = cmp_irq_flag;
		end else if (acc_hit(avs_address, ACC_OFS_PIN_DIS)) begin
			rd_value[1:0] = pin_dis;
		end else if (acc_hit(avs_address, ACC_OFS_CONV_B)) begin
			rd_value[ACC_CONVB_MUX_EN] = cmp_mux_enable;
		end else if (acc_hit(avs_address, ACC_OFS_STATUS)) begin
			rd_value[ACC_STAT_W-1:0] = status;
		end else if (acc_hit(avs_address, ACC_OFS_MASK)) begin
			rd_value[ACC_STAT_W-1:0] = mask;
		end
	end

	// read data captured in the wait cycle, held through the commit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && bus_state == ACC_BUS_IDLE) begin
			avs_readdata <= rd_value;
		end
	end

	// writable control bits of the control/status register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			csr_rw <= ACC_CSR_RESET;
		end else if (wr_csr) begin
			csr_rw <= avs_writedata[7:0] & ACC_CSR_RW_MASK;
		end
	end

	// interrupt flag; a new event beats any clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmp_irq_flag <= 1'b0;
		end else if (evt.evt_mode) begin
			cmp_irq_flag <= 1'b1;
		end else if (cmp_irq_vector_ack) begin
			cmp_irq_flag <= 1'b0;
		end else if (wr_csr && avs_writedata[ACC_CSR_FLAG]) begin
			cmp_irq_flag <= 1'b0;
		end
	end

	// no guard against mode changes: software must drop the enable first
	assign cmp_irq_req = cmp_irq_flag & csr_rw[ACC_CSR_IRQ_EN]
		& global_irq_enable;

	// pin input disables and converter mux enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_dis <= ACC_DIS_RESET;
		end else if (wr_dis) begin
			pin_dis <= avs_writedata[1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmp_mux_enable <= 1'b0;
		end else if (wr_convb) begin
			cmp_mux_enable <= avs_writedata[ACC_CONVB_MUX_EN];
		end
	end

	// analog controls straight from their register bits
	assign cmp_power_off = csr_rw[ACC_CSR_PWR_OFF];
	assign cmp_bandgap_select = csr_rw[ACC_CSR_BANDGAP];
	assign pos_pin_input_disable = pin_dis[ACC_DIS_POS];
	assign neg_pin_input_disable = pin_dis[ACC_DIS_NEG];

	// negative input select; the converter owns the mux while it runs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmp_neg_from_mux <= 1'b0;
			cmp_neg_channel <= 3'h0;
		end else begin
			cmp_neg_from_mux <= cmp_mux_enable & ~converter_on;
			cmp_neg_channel <= channel_select;
		end
	end

	// gated pin readback, zero while the buffer is off
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pos_pin_read <= 1'b0;
			neg_pin_read <= 1'b0;
		end else begin
			pos_pin_read <= pin_sync[1] & ~pin_dis[ACC_DIS_POS];
			neg_pin_read <= pin_sync[2] & ~pin_dis[ACC_DIS_NEG];
		end
	end

	// capture path; the timer adds its own noise canceler and edge select
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmp_capture_sig <= 1'b0;
			cmp_capture_irq <= 1'b0;
		end else begin
			cmp_capture_sig <= csr_rw[ACC_CSR_ROUTE] & cmp_output_sync;
			cmp_capture_irq <= csr_rw[ACC_CSR_ROUTE] & timer_capture_event
				& timer_capture_irq_enable;
		end
	end

	// event status: only bits actually returned by the read are cleared
	assign stat_clr = rd_stat ? avs_readdata[ACC_STAT_W-1:0]
		: ACC_STAT_RESET;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status <= ACC_STAT_RESET;
		end else begin
			status <= (status & ~stat_clr)
				| {evt.evt_toggle, evt.evt_mode};
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mask <= ACC_STAT_RESET;
		end else if (wr_mask) begin
			mask <= avs_writedata[ACC_STAT_W-1:0];
		end
	end

	assign irq = |(status & mask);

	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);

	sync_latency_a: assert property (cmp_raw [*2] |=> cmp_output_sync)
		else $error("comparator output not synchronised in time");
	flag_set_a: assert property (evt.evt_mode |=> cmp_irq_flag)
		else $error("mode event did not set the flag");
	vector_clear_a: assert property (
		cmp_irq_vector_ack && !evt.evt_mode |=> !cmp_irq_flag)
		else $error("vector entry did not clear the flag");
	flag_w1c_a: assert property (
		wr_csr && avs_writedata[ACC_CSR_FLAG] && !evt.evt_mode
		|=> !cmp_irq_flag)
		else $error("write one did not clear the flag");
	flag_keep_a: assert property (
		wr_csr && !avs_writedata[ACC_CSR_FLAG] && cmp_irq_flag
		&& !cmp_irq_vector_ack |=> cmp_irq_flag)
		else $error("write zero disturbed the flag");
	enable_block_a: assert property (
		wr_csr && !avs_writedata[ACC_CSR_IRQ_EN] |=> !cmp_irq_req)
		else $error("cleared enable did not block the request");
	irq_gate_a: assert property (
		cmp_irq_req |-> cmp_irq_flag && global_irq_enable
		&& csr_rw[ACC_CSR_IRQ_EN])
		else $error("request without flag and enables");
	route_off_a: assert property (
		!csr_rw[ACC_CSR_ROUTE] |=> !cmp_capture_sig && !cmp_capture_irq)
		else $error("capture path active with route off");
	neg_pin_a: assert property ((converter_on || !cmp_mux_enable)
		|=> !cmp_neg_from_mux)
		else $error("mux used while disabled or converter on");
	neg_mux_a: assert property ((cmp_mux_enable && !converter_on)
		|=> cmp_neg_from_mux && cmp_neg_channel == $past(channel_select))
		else $error("mux channel not applied");
	pin_gate_a: assert property (
		$past(pin_dis[ACC_DIS_POS]) |-> !pos_pin_read)
		else $error("disabled pin read non-zero");
	bus_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held more than one cycle");

	cover_w1c_c: cover property (wr_csr && avs_writedata[ACC_CSR_FLAG]
		&& cmp_irq_flag);
	cover_vec_c: cover property (cmp_irq_vector_ack && cmp_irq_flag);
	cover_irq_c: cover property (irq && cmp_irq_req);
endmodule

// ==== acc_pkg.sv ====
// Purpose: shared constants and types of the comparator control block
// Assumes: 32-bit avalon slave, byte addresses, one word per register
// Notes: register offsets and the event status layout are local choices
package acc_pkg;

	// register byte offsets
	localparam int ACC_AW = 5;
	localparam logic [4:0] ACC_OFS_CSR = 5'h00;
	localparam logic [4:0] ACC_OFS_PIN_DIS = 5'h04;
	localparam logic [4:0] ACC_OFS_CONV_B = 5'h08;
	localparam logic [4:0] ACC_OFS_STATUS = 5'h0C;
	localparam logic [4:0] ACC_OFS_MASK = 5'h10;

	// comparator_control_status fields
	localparam int ACC_CSR_PWR_OFF = 7;
	localparam int ACC_CSR_BANDGAP = 6;
	localparam int ACC_CSR_OUTPUT = 5;
	localparam int ACC_CSR_FLAG = 4;
	localparam int ACC_CSR_IRQ_EN = 3;
	localparam int ACC_CSR_ROUTE = 2;
	localparam int ACC_CSR_MODE_HI = 1;
	localparam int ACC_CSR_MODE_LO = 0;
	localparam logic [7:0] ACC_CSR_RW_MASK = 8'hCF;
	localparam logic [7:0] ACC_CSR_RESET = 8'h00;

	// comparator_pin_input_disable fields
	localparam int ACC_DIS_NEG = 1;
	localparam int ACC_DIS_POS = 0;
	localparam logic [1:0] ACC_DIS_RESET = 2'h0;

	// converter_ctrl_status_b field held here
	localparam int ACC_CONVB_MUX_EN = 6;

	// event status and mask layout
	localparam int ACC_STAT_W = 2;
	localparam int ACC_STAT_CMP = 0;
	localparam int ACC_STAT_TOGGLE = 1;
	localparam logic [1:0] ACC_STAT_RESET = 2'h0;

	// interrupt mode codes
	localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
	localparam logic [1:0] ACC_MODE_RSVD = 2'h1;
	localparam logic [1:0] ACC_MODE_FALL = 2'h2;
	localparam logic [1:0] ACC_MODE_RISE = 2'h3;

	// synchroniser depth
	localparam int ACC_SYNC_STAGES = 2;

	// bus handshake states
	typedef enum logic [1:0] {
		ACC_BUS_IDLE = 2'b01,
		ACC_BUS_DONE = 2'b10
	} acc_bus_t;

	// word address match, low two byte bits ignored
	function automatic logic acc_hit(input logic [4:0] addr,
		input logic [4:0] ofs);
		return addr[4:2] == ofs[4:2];
	endfunction

endpackage

// ==== acc_evt_if.sv ====
// Purpose: carries the synchronised comparator level and its events
// Assumes: single clock domain
// Notes: core drives level and mode, detector answers with event pulses
`timescale 1ns/1ps
interface acc_evt_if;
	logic cmp_level;
	logic [1:0] mode;
	logic evt_mode;
	logic evt_toggle;
	modport core (output cmp_level, output mode, input evt_mode,
		input evt_toggle);
	modport det (input cmp_level, input mode, output evt_mode,
		output evt_toggle);
endinterface

// ==== acc_sync.sv ====
// Purpose: multi-bit level synchroniser for asynchronous inputs
// Assumes: each bit is an independent slow level
// Notes: only the next stage reads the first stage
`timescale 1ns/1ps
module acc_sync #(
	parameter int WIDTH = 3,
	parameter int STAGES = acc_pkg::ACC_SYNC_STAGES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import acc_pkg::*;

	logic [WIDTH-1:0] stage [STAGES];

	// refuse depths that cannot settle metastability
	generate
		if (STAGES < 2) begin : g_bad
			$error("acc_sync needs at least two stages");
		end
	endgenerate

	// first stage samples the pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage[0] <= '0;
		end else begin
			stage[0] <= async_in;
		end
	end

	// remaining stages form a plain shift chain
	genvar i;
	generate
		for (i = 1; i < STAGES; i++) begin : g_stage
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					stage[i] <= '0;
				end else begin
					stage[i] <= stage[i-1];
				end
			end
		end
	endgenerate

	assign sync_out = stage[STAGES-1];
endmodule

// ==== acc_edge.sv ====
// Purpose: toggle, rise and fall detection with mode selection
// Assumes: level input already synchronised to clk
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
module acc_edge (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// event port
	acc_evt_if.det evt
);
	import acc_pkg::*;

	logic prev;
	logic rise;
	logic fall;

	// previous level, compared every clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev <= 1'b0;
		end else begin
			prev <= evt.cmp_level;
		end
	end

	assign rise = evt.cmp_level & ~prev;
	assign fall = ~evt.cmp_level & prev;
	assign evt.evt_toggle = evt.cmp_level ^ prev;

	// reserved code never fires, so a bad mode cannot flood the cpu
	always_comb begin
		unique case (evt.mode)
			ACC_MODE_TOGGLE: evt.evt_mode = evt.evt_toggle;
			ACC_MODE_FALL: evt.evt_mode = fall;
			ACC_MODE_RISE: evt.evt_mode = rise;
			default: evt.evt_mode = 1'b0;
		endcase
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);

	mode_rise_a: assert property (evt.mode == ACC_MODE_RISE
		|-> evt.evt_mode == (evt.cmp_level && !$past(evt.cmp_level)))
		else $error("rise mode event mismatch");
	mode_fall_a: assert property (evt.mode == ACC_MODE_FALL
		|-> evt.evt_mode == (!evt.cmp_level && $past(evt.cmp_level)))
		else $error("fall mode event mismatch");
	mode_toggle_a: assert property (evt.mode == ACC_MODE_TOGGLE
		|-> evt.evt_mode == $changed(evt.cmp_level))
		else $error("toggle mode event mismatch");
	reserved_silent_a: assert property (evt.mode == ACC_MODE_RSVD
		|-> !evt.evt_mode)
		else $error("reserved mode produced an event");

	cover_rise_c: cover property (evt.mode == ACC_MODE_RISE && evt.evt_mode);
	cover_fall_c: cover property (evt.mode == ACC_MODE_FALL && evt.evt_mode);
endmodule

// ==== acc_far_model.sv ====
// Purpose: analog comparator core and timer capture front end
// Assumes: levels are coarse steps, a higher step is a higher voltage
// Notes: a powered-down core is held low, a guess on our side
`timescale 1ns/1ps
module acc_far_model #(
	parameter logic [3:0] BG_LEVEL = 4'hA
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// analog levels from the bench
	input wire logic [3:0] pos_level,
	input wire logic [3:0] neg_level,
	input wire logic [31:0] chan_levels,
	// comparator controls
	input wire logic cmp_power_off,
	input wire logic cmp_bandgap_select,
	input wire logic cmp_neg_from_mux,
	input wire logic [2:0] cmp_neg_channel,
	output logic cmp_raw,
	// timer capture
	input wire logic cmp_capture_sig,
	output logic timer_capture_event
);
	logic [3:0] plus_in;
	logic [3:0] minus_in;
	logic prev_sig;
	// inputs seen by the analog core
	assign plus_in = cmp_bandgap_select ? BG_LEVEL : pos_level;
	assign minus_in = cmp_neg_from_mux ?
		chan_levels[{cmp_neg_channel, 2'b00} +: 4] : neg_level;
	assign cmp_raw = !cmp_power_off && (plus_in > minus_in);
	// rising edge select, noise canceler off: one cycle event
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_sig <= 1'b0;
			timer_capture_event <= 1'b0;
		end else begin
			prev_sig <= cmp_capture_sig;
			timer_capture_event <= cmp_capture_sig && !prev_sig;
		end
	end
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench of the comparator control block
// Assumes: one wait cycle per bus access, as the design answers
// Notes: all drives land by non-blocking assignment on rising edges
`timescale 1ns/1ps
module testbench;
	import acc_pkg::*;
	localparam int LIMIT = 20000;
	logic clk = 1'b0, rstn = 1'b0;
	logic [ACC_AW-1:0] avs_address = '0;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic avs_waitrequest, irq, cmp_irq_req, cmp_raw, cmp_power_off;
	logic global_irq_enable = 1'b0, cmp_irq_vector_ack = 1'b0;
	logic cmp_bandgap_select, cmp_neg_from_mux, cmp_capture_sig;
	logic [2:0] cmp_neg_channel, channel_select = 3'h0;
	logic converter_on = 1'b0, pos_pin_raw = 1'b0, neg_pin_raw = 1'b0;
	logic pos_pin_read, neg_pin_read, pos_pin_input_disable;
	logic neg_pin_input_disable, timer_capture_event, cmp_capture_irq;
	logic timer_capture_irq_enable = 1'b0;
	logic [3:0] pos_level = 4'h4, neg_level = 4'h8;
	logic [31:0] chan_levels = 32'h9292_9292;
	int fails = 0, checked = 0, cycles = 0;

	acc_ctrl #(.SYNC_STAGES(ACC_SYNC_STAGES)) i_acc_ctrl (.clk(clk),
		.rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq),
		.global_irq_enable(global_irq_enable),
		.cmp_irq_vector_ack(cmp_irq_vector_ack), .cmp_irq_req(cmp_irq_req),
		.cmp_raw(cmp_raw), .cmp_power_off(cmp_power_off),
		.cmp_bandgap_select(cmp_bandgap_select),
		.cmp_neg_from_mux(cmp_neg_from_mux),
		.cmp_neg_channel(cmp_neg_channel), .converter_on(converter_on),
		.channel_select(channel_select), .pos_pin_raw(pos_pin_raw),
		.neg_pin_raw(neg_pin_raw), .pos_pin_read(pos_pin_read),
		.neg_pin_read(neg_pin_read),
		.pos_pin_input_disable(pos_pin_input_disable),
		.neg_pin_input_disable(neg_pin_input_disable),
		.timer_capture_event(timer_capture_event),
		.timer_capture_irq_enable(timer_capture_irq_enable),
		.cmp_capture_sig(cmp_capture_sig), .cmp_capture_irq(cmp_capture_irq));
	acc_far_model i_acc_far_model (.clk(clk), .rstn(rstn),
		.pos_level(pos_level), .neg_level(neg_level),
		.chan_levels(chan_levels), .cmp_power_off(cmp_power_off),
		.cmp_bandgap_select(cmp_bandgap_select),
		.cmp_neg_from_mux(cmp_neg_from_mux),
		.cmp_neg_channel(cmp_neg_channel), .cmp_raw(cmp_raw),
		.cmp_capture_sig(cmp_capture_sig),
		.timer_capture_event(timer_capture_event));

	// 40 MHz clock
	always #12.5 clk = ~clk;
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			final_report();
		end
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", w, e, s);
		end
	endtask
	// one access, held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !w;
		avs_write <= w;
		// no local limit: only the hang guard ends a stuck wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string w, input logic [4:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(w, q, e);
	endtask
	// settle: let edges pass, then look at the falling edge
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic drive_cmp(input logic hi);
		@(posedge clk);
		pos_level <= hi ? 4'hC : 4'h4;
	endtask
	task automatic set_cmp(input logic hi);
		drive_cmp(hi);
		settle(4);
	endtask
	function automatic logic [31:0] csr_v(input logic o, f,
		input logic [3:0] lo);
		return {26'h0, o, f, lo};
	endfunction

	task automatic t_regs;
		logic [4:0] ofs[6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
		foreach (ofs[i]) rd("reset value", ofs[i], 0);
		wr(ACC_OFS_CSR, 8'hF6);
		rd("csr access", ACC_OFS_CSR, 32'hC6);
		wr(ACC_OFS_CSR, 8'h00);
		wr(ACC_OFS_CONV_B, 8'hFF);
		rd("mux enable bit", ACC_OFS_CONV_B, 32'h40);
		// mux off again, channel 0 would otherwise hold the output high
		wr(ACC_OFS_CONV_B, 8'h00);
		wr(5'h14, 8'hFF);
		rd("unmapped", 5'h14, 0);
	endtask
	task automatic t_modes;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			wr(ACC_OFS_CSR, {6'h04, m});
			set_cmp(1'b1);
			rd("rise", ACC_OFS_CSR, csr_v(1, m == 0 || m == 3, m));
			wr(ACC_OFS_CSR, {6'h00, m});
			rd("zero write", ACC_OFS_CSR, csr_v(1, m == 0 || m == 3, m));
			wr(ACC_OFS_CSR, {6'h04, m});
			rd("one write", ACC_OFS_CSR, csr_v(1, 0, m));
			set_cmp(1'b0);
			rd("fall", ACC_OFS_CSR, csr_v(0, m == 0 || m == 2, m));
		end
	endtask
	task automatic t_irq;
		wr(ACC_OFS_CSR, 8'h13);
		wr(ACC_OFS_CSR, 8'h0B);
		set_cmp(1'b1);
		chk("req, global off", cmp_irq_req, 0);
		@(posedge clk) global_irq_enable <= 1'b1;
		settle(0);
		chk("req", cmp_irq_req, 1);
		wr(ACC_OFS_CSR, 8'h03);
		settle(1);
		chk("req, enable off", cmp_irq_req, 0);
		wr(ACC_OFS_CSR, 8'h0B);
		settle(1);
		chk("req again", cmp_irq_req, 1);
		@(posedge clk) cmp_irq_vector_ack <= 1'b1;
		@(posedge clk) cmp_irq_vector_ack <= 1'b0;
		rd("vector entry", ACC_OFS_CSR, csr_v(1, 0, 4'hB));
		wr(ACC_OFS_CSR, 8'h03);
		set_cmp(1'b0);
	endtask
	task automatic t_status;
		logic [31:0] q;
		bus(1'b0, ACC_OFS_STATUS, 8'h00, q);
		wr(ACC_OFS_MASK, 8'h01);
		set_cmp(1'b1);
		chk("irq", irq, 1);
		rd("status rise", ACC_OFS_STATUS, 32'h3);
		settle(1);
		chk("irq after read", irq, 0);
		rd("status cleared", ACC_OFS_STATUS, 0);
		wr(ACC_OFS_MASK, 8'h02);
		set_cmp(1'b0);
		chk("irq toggle", irq, 1);
		rd("status fall", ACC_OFS_STATUS, 32'h2);
		wr(ACC_OFS_MASK, 8'h00);
		set_cmp(1'b1);
		chk("irq masked", irq, 0);
		rd("status masked", ACC_OFS_STATUS, 32'h3);
		set_cmp(1'b0);
	endtask
	task automatic t_capture;
		int ev, ci;
		@(posedge clk) timer_capture_irq_enable <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			if (r == 2) @(posedge clk) timer_capture_irq_enable <= 1'b0;
			wr(ACC_OFS_CSR, r == 0 ? 8'h03 : 8'h07);
			ev = 0;
			ci = 0;
			drive_cmp(1'b1);
			repeat (10) begin
				@(negedge clk);
				ev += int'(timer_capture_event === 1'b1);
				ci += int'(cmp_capture_irq === 1'b1);
			end
			chk("capture path", cmp_capture_sig, r != 0);
			chk("capture events", ev, r != 0);
			chk("capture irq", ci, r == 1);
			set_cmp(1'b0);
			chk("capture path low", cmp_capture_sig, 0);
		end
		// reserved mode, and drop the flag left by the rising captures
		wr(ACC_OFS_CSR, 8'h11);
	endtask
	task automatic t_mux;
		logic [2:0] c;
		wr(ACC_OFS_CONV_B, 8'h40);
		for (int k = 0; k < 8; k++) begin
			c = k[2:0];
			@(posedge clk) channel_select <= c;
			settle(4);
			chk("neg from mux", cmp_neg_from_mux, 1);
			chk("neg channel", cmp_neg_channel, c);
			rd("via channel", ACC_OFS_CSR, csr_v(!c[0], 0, 4'h1));
		end
		@(posedge clk) converter_on <= 1'b1;
		settle(4);
		chk("converter on", cmp_neg_from_mux, 0);
		rd("neg pin used", ACC_OFS_CSR, csr_v(0, 0, 4'h1));
		@(posedge clk) converter_on <= 1'b0;
		wr(ACC_OFS_CONV_B, 8'h00);
		settle(2);
		chk("mux off", cmp_neg_from_mux, 0);
		wr(ACC_OFS_CSR, 8'h41);
		settle(4);
		chk("bandgap", cmp_bandgap_select, 1);
		rd("bandgap compare", ACC_OFS_CSR, 32'h61);
		wr(ACC_OFS_CSR, 8'hC1);
		settle(4);
		chk("power off", cmp_power_off, 1);
		rd("powered down", ACC_OFS_CSR, 32'hC1);
		wr(ACC_OFS_CSR, 8'h01);
	endtask
	task automatic t_pins;
		@(posedge clk);
		pos_pin_raw <= 1'b1;
		neg_pin_raw <= 1'b1;
		settle(4);
		chk("pins enabled", {pos_pin_read, neg_pin_read}, 2'b11);
		wr(ACC_OFS_PIN_DIS, 8'hFF);
		rd("disable reg", ACC_OFS_PIN_DIS, 32'h3);
		settle(4);
		chk("pins off", {pos_pin_read, neg_pin_read}, 0);
		chk("buffers off", {neg_pin_input_disable, pos_pin_input_disable}, 3);
		wr(ACC_OFS_PIN_DIS, 8'h01);
		settle(4);
		chk("one pin off", {pos_pin_read, neg_pin_read}, 2'b01);
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		$display("registers done");
		t_modes();
		$display("modes done");
		t_irq();
		$display("request done");
		t_status();
		$display("status done");
		t_capture();
		$display("capture done");
		t_mux();
		$display("inputs done");
		t_pins();
		$display("pins done");
		final_report();
	end
endmodule
